// file: src/pmw_pkg.sv
// constants for the power mode and interrupt wakeup block
// assumes a 32-bit classic Wishbone slave port and a single 125 MHz clock
package pmw_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] WAKE_CTRL_ADDR = 32'hFFF00020;
  localparam logic [31:0] WAKE_CAUSE_ADDR = 32'hFFF00024;
  localparam logic [31:0] PMODE_ADDR = 32'hFFF00028;
  localparam logic [31:0] INT_STAT_ADDR = 32'hFFF0002C;
  localparam logic [31:0] INT_MASK_ADDR = 32'hFFF00038;
  localparam int NPINS = 2;
  localparam int EXTERNAL_IRQ_N = 4;
  localparam int NPERIPH = 8;
  localparam int EN_LSB = 0;
  localparam int POL_LSB = 4;
  localparam int PM_IDLE_BIT = 0;
  localparam int PM_PD_BIT = 1;
  localparam int PM_MEMCTL_HALT_ENABLE_BIT = 2;
  localparam int NEV = 3;
  localparam int EV_WAKE = 0;
  localparam int EV_IDLE_EXIT = 1;
  localparam int EV_PD_EXIT = 2;
  localparam logic [31:0] ZERO32 = 32'h00000000;
  typedef enum logic [1:0] {PMW_RUN, PMW_IDLE, PMW_PDOWN} pmw_state_t;
endpackage : pmw_pkg

// file: src/pmw_power_ctrl.sv
// power mode controller with wakeup sources and classic Wishbone registers
// assumes synchronous inputs, single clock mclk, synchronous active-high reset
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
module pmw_power_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pmw_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [pmw_pkg::EXTERNAL_IRQ_N-1:0] external_irq_n,
  input wire logic fast_irq_n,
  input wire logic keypadWake,
  input wire logic extResetWake,
  input wire logic [pmw_pkg::NPERIPH-1:0] clock_select_reg,
  output logic coreClkEn,
  output logic memctlClkEn,
  output logic oscPllEn,
  output logic [pmw_pkg::NPERIPH-1:0] periphClkEn,
  output logic irq
);
  import pmw_pkg::*;

  logic [NPINS-1:0] wakeSourceEnable, next_wakeSourceEnable;
  logic [NPINS-1:0] wakeLevelSelect, next_wakeLevelSelect;
  logic [NPINS-1:0] wakeCauseFlag, next_wakeCauseFlag;
  logic coreIdleBit, next_coreIdleBit;
  logic powerDownEnable, next_powerDownEnable;
  logic memctlHaltEnable, next_memctlHaltEnable;
  logic [NEV-1:0] intStat, next_intStat;
  logic [NEV-1:0] intMask, next_intMask;
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  pmw_state_t state, next_state;
  logic next_coreClkEn, next_memctlClkEn, next_oscPllEn, next_irq;
  logic [NPERIPH-1:0] next_periphClkEn;
  logic [NPINS-1:0] wakeHit;
  logic wrStrobe, rdStrobe, anyIrq, pdWake;
  logic [NEV-1:0] ev;

  pmw_wake_detect u_detect (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pinN(external_irq_n[NPINS-1:0]),
    .wakeSourceEnable(wakeSourceEnable),
    .wakeLevelSelect(wakeLevelSelect),
    .wakeHit(wakeHit)
  );

  // bus strobes: one-cycle ack; a write lands at the edge where the master sees ack high
  always_comb begin
    wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    rdStrobe = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    anyIrq = (~&external_irq_n) | ~fast_irq_n;
    pdWake = (|wakeHit) | keypadWake | extResetWake;
  end

  // power state sequencing
  always_comb begin
    next_state = state;
    ev = '0;
    next_wakeCauseFlag = wakeCauseFlag;
    case (state)
      PMW_RUN: begin
        if (powerDownEnable) begin
          next_state = PMW_PDOWN;
        end else if (coreIdleBit) begin
          next_state = PMW_IDLE;
        end
      end
      PMW_IDLE: begin
        if (anyIrq) begin
          next_state = PMW_RUN;
          ev[EV_IDLE_EXIT] = 1'b1;
        end
      end
      PMW_PDOWN: begin
        if (pdWake) begin
          next_state = PMW_RUN;
          ev[EV_PD_EXIT] = 1'b1;
          if (|wakeHit) begin
            ev[EV_WAKE] = 1'b1;
          end
        end
      end
      default: begin
        next_state = PMW_RUN;
      end
    endcase
    // software write-one clears cause flags, a new wake wins over the clear
    if (wrStrobe && wb_adr_i == WAKE_CAUSE_ADDR) begin
      next_wakeCauseFlag = wakeCauseFlag & ~wb_dat_i[NPINS-1:0];
    end
    if (state == PMW_PDOWN && pdWake) begin
      next_wakeCauseFlag = next_wakeCauseFlag | wakeHit;
    end
  end

  // control registers and interrupt status
  always_comb begin
    next_wakeSourceEnable = wakeSourceEnable;
    next_wakeLevelSelect = wakeLevelSelect;
    next_coreIdleBit = coreIdleBit;
    next_powerDownEnable = powerDownEnable;
    next_memctlHaltEnable = memctlHaltEnable;
    next_intMask = intMask;
    next_intStat = intStat;
    if (wrStrobe) begin
      case (wb_adr_i)
        WAKE_CTRL_ADDR: begin
          next_wakeSourceEnable = wb_dat_i[EN_LSB +: NPINS];
          next_wakeLevelSelect = wb_dat_i[POL_LSB +: NPINS];
        end
        PMODE_ADDR: begin
          next_coreIdleBit = wb_dat_i[PM_IDLE_BIT];
          next_powerDownEnable = wb_dat_i[PM_PD_BIT];
          next_memctlHaltEnable = wb_dat_i[PM_MEMCTL_HALT_ENABLE_BIT];
        end
        INT_STAT_ADDR: begin
          next_intStat = intStat & ~wb_dat_i[NEV-1:0];
        end
        INT_MASK_ADDR: begin
          next_intMask = wb_dat_i[NEV-1:0];
        end
        default: begin
        end
      endcase
    end
    // leaving a mode drops its request bit so the core does not re-enter
    if (ev[EV_IDLE_EXIT]) begin
      next_coreIdleBit = 1'b0;
    end
    if (ev[EV_PD_EXIT]) begin
      next_powerDownEnable = 1'b0;
    end
    next_intStat = next_intStat | ev;
  end

  // read mux and outputs
  always_comb begin
    next_wb_ack_o = rdStrobe;
    next_wb_dat_o = ZERO32;
    if (rdStrobe && !wb_we_i) begin
      case (wb_adr_i)
        WAKE_CTRL_ADDR: begin
          next_wb_dat_o[EN_LSB +: NPINS] = wakeSourceEnable;
          next_wb_dat_o[POL_LSB +: NPINS] = wakeLevelSelect;
        end
        WAKE_CAUSE_ADDR: begin
          next_wb_dat_o[NPINS-1:0] = wakeCauseFlag;
        end
        PMODE_ADDR: begin
          next_wb_dat_o[PM_IDLE_BIT] = coreIdleBit;
          next_wb_dat_o[PM_PD_BIT] = powerDownEnable;
          next_wb_dat_o[PM_MEMCTL_HALT_ENABLE_BIT] = memctlHaltEnable;
        end
        INT_STAT_ADDR: begin
          next_wb_dat_o[NEV-1:0] = intStat;
        end
        INT_MASK_ADDR: begin
          next_wb_dat_o[NEV-1:0] = intMask;
        end
        default: begin
          next_wb_dat_o = ZERO32;
        end
      endcase
    end
    next_coreClkEn = (next_state == PMW_RUN);
    next_oscPllEn = (next_state != PMW_PDOWN);
    // memory clock halts in power-down, and while idle only with memctlHaltEnable set
    next_memctlClkEn = (next_state == PMW_RUN) ||
                       (next_state == PMW_IDLE && !memctlHaltEnable);
    next_periphClkEn = (next_state == PMW_PDOWN) ? '0 : clock_select_reg;
    next_irq = |(next_intStat & intMask);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= PMW_RUN;
      wakeSourceEnable <= '0;
      wakeLevelSelect <= '0;
      wakeCauseFlag <= '0;
      coreIdleBit <= 1'b0;
      powerDownEnable <= 1'b0;
      memctlHaltEnable <= 1'b0;
      intStat <= '0;
      intMask <= '0;
      wb_dat_o <= ZERO32;
      wb_ack_o <= 1'b0;
      coreClkEn <= 1'b1;
      memctlClkEn <= 1'b1;
      oscPllEn <= 1'b1;
      periphClkEn <= '0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      wakeSourceEnable <= next_wakeSourceEnable;
      wakeLevelSelect <= next_wakeLevelSelect;
      wakeCauseFlag <= next_wakeCauseFlag;
      coreIdleBit <= next_coreIdleBit;
      powerDownEnable <= next_powerDownEnable;
      memctlHaltEnable <= next_memctlHaltEnable;
      intStat <= next_intStat;
      intMask <= next_intMask;
      wb_dat_o <= next_wb_dat_o;
      wb_ack_o <= next_wb_ack_o;
      coreClkEn <= next_coreClkEn;
      memctlClkEn <= next_memctlClkEn;
      oscPllEn <= next_oscPllEn;
      periphClkEn <= next_periphClkEn;
      irq <= next_irq;
    end
  end
endmodule : pmw_power_ctrl

// file: src/pmw_wake_detect.sv
// wake pin qualifier: per pin level match, enable gate
// assumes pins already synchronous to mclk
`timescale 1ns/10ps
module pmw_wake_detect (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [pmw_pkg::NPINS-1:0] pinN,
  input wire logic [pmw_pkg::NPINS-1:0] wakeSourceEnable,
  input wire logic [pmw_pkg::NPINS-1:0] wakeLevelSelect,
  output logic [pmw_pkg::NPINS-1:0] wakeHit
);
  import pmw_pkg::*;
  logic [NPINS-1:0] next_wakeHit;
  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      // pin level compared against selected polarity, gated by enable
      always_comb begin
        next_wakeHit[i] = wakeSourceEnable[i] & (pinN[i] == wakeLevelSelect[i]);
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wakeHit <= '0;
    end else begin
      wakeHit <= next_wakeHit;
    end
  end
endmodule : pmw_wake_detect

// file: verif/pmw_asserts.sv
// checker for the power mode block: bus answer and clock gating relations
// bound into pmw_power_ctrl, sees its ports only
`timescale 1ns/10ps
module pmw_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [pmw_pkg::EXTERNAL_IRQ_N-1:0] external_irq_n,
  input wire logic fast_irq_n,
  input wire logic keypadWake,
  input wire logic extResetWake,
  input wire logic [pmw_pkg::NPERIPH-1:0] clock_select_reg,
  input wire logic coreClkEn,
  input wire logic memctlClkEn,
  input wire logic oscPllEn,
  input wire logic [pmw_pkg::NPERIPH-1:0] periphClkEn
);
  import pmw_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_pulse; endproperty
  property p_dat; !wb_ack_o |-> wb_dat_o == ZERO32; endproperty
  property p_per; oscPllEn && $past(oscPllEn) |-> periphClkEn == $past(clock_select_reg); endproperty
  property p_pdz; !oscPllEn |-> !coreClkEn && !memctlClkEn && periphClkEn == '0; endproperty
  property p_mem; coreClkEn |-> memctlClkEn; endproperty
  property p_idle; oscPllEn && !coreClkEn && (!fast_irq_n || external_irq_n != '1) |=> coreClkEn;
  endproperty
  property p_pdw; !oscPllEn && (keypadWake || extResetWake) |-> ##[1:3] oscPllEn; endproperty
  property p_up; $rose(oscPllEn) |-> coreClkEn && memctlClkEn; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  a_dat: assert property (p_dat) else $error("read data outside ack");
  a_per: assert property (p_per) else $error("peripheral clocks wrong");
  a_pdz: assert property (p_pdz) else $error("clock up in power-down");
  a_mem: assert property (p_mem) else $error("memory clock halted early");
  a_idle: assert property (p_idle) else $error("idle not ended");
  a_pdw: assert property (p_pdw) else $error("no power-down exit");
  a_up: assert property (p_up) else $error("clocks not restored");
endmodule : pmw_asserts
bind pmw_power_ctrl pmw_asserts u_chk (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .external_irq_n, .fast_irq_n, .keypadWake, .extResetWake, .clock_select_reg,
  .coreClkEn, .memctlClkEn, .oscPllEn, .periphClkEn);

// file: verif/pmw_irq_pins.sv
// pin model: interrupt lines as the bench commands them
// assumes the bench changes its commands on mclk rising edges
`timescale 1ns/10ps
module pmw_irq_pins (
  input wire logic [3:0] drvLow,
  input wire logic fastLow,
  output logic [3:0] external_irq_n,
  output logic fastIrqN
);
  assign external_irq_n = ~drvLow;
  assign fastIrqN = ~fastLow;
endmodule : pmw_irq_pins

// file: verif/power_mode_and_irq_wakeup_tb.sv
// bench for pmw_power_ctrl: wishbone master, pin model, inline expectations
// assumes pmw_pkg, pmw_irq_pins and pmw_asserts are compiled first
`timescale 1ns/10ps
module power_mode_and_irq_wakeup_tb;
  import pmw_pkg::*;
  logic mclk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, fastLow = 0, kp = 0, er = 0;
  logic [31:0] adr = 0, wdat = 0, q, r;
  logic [3:0] drvLow = 0;
  logic [NPERIPH-1:0] csr = 0;
  logic [31:0] addrs [5] = '{WAKE_CTRL_ADDR, WAKE_CAUSE_ADDR, PMODE_ADDR, INT_MASK_ADDR,
    32'hFFF00030};
  wire logic [31:0] rdat;
  wire logic ack, fastN, cClk, mClk, oClk, irq;
  wire logic [3:0] irqN;
  wire logic [NPERIPH-1:0] pClk;
  int failures = 0, checks = 0, i;
  initial forever #4 mclk = ~mclk;
  pmw_irq_pins u_pins (.drvLow(drvLow), .fastLow(fastLow), .external_irq_n(irqN),
    .fastIrqN(fastN));
  pmw_power_ctrl u_dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .external_irq_n(irqN), .fast_irq_n(fastN), .keypadWake(kp),
    .extResetWake(er), .clock_select_reg(csr), .coreClkEn(cClk), .memctlClkEn(mClk),
    .oscPllEn(oClk), .periphClkEn(pClk), .irq(irq));
  task automatic stop_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge mclk);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n == 20) chk(32'h0, 32'h1);
    if (n == 20) stop_test();
  endtask : wb
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, ZERO32);
    chk(q, e);
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  task automatic wait_osc();
    int n;
    for (n = 0; n < 20 && oClk !== 1'b1; n++) @(posedge mclk);
    chk(32'(oClk), 32'h1);
    if (n == 20) stop_test();
  endtask : wait_osc
  initial begin
    void'($urandom(36009));
    r = $urandom();
    tick(10);
    sys_rst <= 0;
    csr <= NPERIPH'($urandom());
    foreach (addrs[k]) rd(addrs[k], ZERO32);
    wb(1'b1, WAKE_CTRL_ADDR, r);
    rd(WAKE_CTRL_ADDR, r & 32'h33);
    wb(1'b1, PMODE_ADDR, 32'h5); // no SDRAM traffic runs, as if in self-refresh
    tick(3);
    chk({30'h0, cClk, mClk}, 32'h0);
    chk(32'(pClk), 32'(csr));
    fastLow <= 1;
    tick(4);
    chk(32'(cClk), 32'h1);
    rd(PMODE_ADDR, 32'h4);
    fastLow <= 0;
    wb(1'b1, PMODE_ADDR, 32'h1);
    tick(3);
    chk({30'h0, cClk, mClk}, 32'h1);
    drvLow <= 4'h8;
    tick(4);
    chk(32'(cClk), 32'h1);
    wb(1'b1, INT_MASK_ADDR, 32'h7);
    for (i = 0; i < 2; i++) begin
      drvLow <= 4'(i * 2);
      wb(1'b1, WAKE_CTRL_ADDR, i ? 32'h22 : 32'h1);
      wb(1'b1, PMODE_ADDR, 32'h2);
      tick(2);
      chk({29'h0, oClk, cClk, mClk}, 32'h0);
      drvLow <= i ? 4'h3 : 4'h2;
      tick(4);
      chk(32'(oClk), 32'h0);
      drvLow <= i ? 4'h1 : 4'h3;
      wait_osc();
      drvLow <= 4'h0;
      rd(WAKE_CAUSE_ADDR, 32'(1 << i));
      chk(32'(irq), 32'h1);
      wb(1'b1, INT_MASK_ADDR, ZERO32);
      tick(2);
      chk(32'(irq), 32'h0);
      wb(1'b1, WAKE_CAUSE_ADDR, 32'h3);
      wb(1'b1, INT_STAT_ADDR, 32'h7);
      wb(1'b1, INT_MASK_ADDR, 32'h7);
      tick(2);
      chk(32'(irq), 32'h0);
      rd(WAKE_CAUSE_ADDR, ZERO32);
    end
    wb(1'b1, WAKE_CTRL_ADDR, ZERO32);
    for (i = 0; i < 2; i++) begin
      wb(1'b1, PMODE_ADDR, 32'h2);
      tick(2);
      chk(32'(oClk), 32'h0);
      {kp, er} <= 2'(1 << i);
      wait_osc();
      {kp, er} <= 2'b00;
      rd(WAKE_CAUSE_ADDR, ZERO32);
    end
    stop_test();
  end
endmodule : power_mode_and_irq_wakeup_tb
